// File: design/phymux_ahb_slave.sv
// AHB-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
module phymux_ahb_slave
  import phymux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire phymux_pkg::phymux_ahb_req_t req,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] reg_addr,
  output logic hreadyout,
  output logic hresp
);

  ////////////////////////////////////////////////////////////////////////
  // Address-phase decode.
  ////////////////////////////////////////////////////////////////////////

  // A valid word transfer; other sizes or misaligned words are ignored.
  wire logic xfer_valid;
  assign xfer_valid = req.hsel && req.hready && req.hsize == PHYMUX_HSIZE_WORD &&
                      req.haddr[1:0] == PHYMUX_ADDR_LSB_ZERO &&
                      (req.htrans == PHYMUX_HTRANS_NONSEQ || req.htrans == PHYMUX_HTRANS_SEQ);

  logic wr_reg;
  logic rd_reg;
  logic [7:0] addr_reg;

  // Latch the address phase; the data phase follows in the next cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_reg <= xfer_valid && req.hwrite;
      rd_reg <= xfer_valid && !req.hwrite;
      if (xfer_valid) begin
        addr_reg <= req.haddr;
      end
    end
  end

  // Zero wait states, always OKAY; an unmapped address reads zero.
  assign wr_stb = wr_reg;
  assign rd_stb = rd_reg;
  assign reg_addr = addr_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// File: design/phymux_pkg.sv
// Package of constants, enumerations and carriers for the PHY pin-function block.
package phymux_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] PHYMUX_OFS_MODE = 8'h00;
  localparam logic [7:0] PHYMUX_OFS_COLSEL = 8'h04;
  localparam logic [7:0] PHYMUX_OFS_RXD3SEL = 8'h08;
  localparam logic [7:0] PHYMUX_OFS_GPIO = 8'h0C;
  localparam logic [7:0] PHYMUX_OFS_STATUS = 8'h10;
  localparam logic [7:0] PHYMUX_OFS_STRAP = 8'h14;

  // AHB encodings used by the slave.
  localparam logic [1:0] PHYMUX_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PHYMUX_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] PHYMUX_HSIZE_WORD = 3'h2;
  localparam logic [1:0] PHYMUX_ADDR_LSB_ZERO = 2'h0;

  // Field positions inside the registers.
  localparam int PHYMUX_MODE_LSB = 0;
  localparam int PHYMUX_FDX_BIT = 2;
  localparam int PHYMUX_SEL_LSB = 0;
  localparam int PHYMUX_GPIO_OUT_BIT = 0;
  localparam int PHYMUX_GPIO_OE_BIT = 1;

  // Widths.
  localparam int PHYMUX_STRAP_W = 10;
  localparam int PHYMUX_DATA_W = 32;

  // Reset values of the software registers.
  localparam logic [1:0] PHYMUX_MODE_RST = 2'h0;
  localparam logic [1:0] PHYMUX_SEL_RST = 2'h0;
  localparam logic [31:0] PHYMUX_ZERO_WORD = 32'h0000_0000;

  // Strap pull directions during reset: 1 = pull up, 0 = pull down.
  // Order: ind0, crs, col, rxer, ind1, rxdv, rxd0..rxd3.
  localparam logic [9:0] PHYMUX_STRAP_PULLUP = 10'h00F;

  // MAC interface mode.
  typedef enum logic [1:0] {
    PHYMUX_IF_MII = 2'h0,
    PHYMUX_IF_RMII = 2'h1,
    PHYMUX_IF_RGMII = 2'h2
  } phymux_ifmode_t;

  // Function selection of a multiplexed pin.
  typedef enum logic [1:0] {
    PHYMUX_FN_IFACE = 2'h0,
    PHYMUX_FN_LED = 2'h1,
    PHYMUX_FN_GPIO = 2'h2
  } phymux_fn_t;

  // Four-signal pin carrier.
  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
    logic pd;
  } phymux_pad_t;

  // AHB-Lite request carrier.
  typedef struct packed {
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } phymux_ahb_req_t;

endpackage

// File: design/phymux_strap_latch.sv
// Strap capture register that samples the strap pins on reset release.
`timescale 1ns/1ps
module phymux_strap_latch
  import phymux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [PHYMUX_STRAP_W-1:0] strap_in,
  output logic [PHYMUX_STRAP_W-1:0] strap_q
);

  ////////////////////////////////////////////////////////////////////////
  // Capture on the first clock after reset releases.
  ////////////////////////////////////////////////////////////////////////

  logic srst_d_reg;
  logic [PHYMUX_STRAP_W-1:0] strap_reg;

  // The pins are held by their pulls during reset, so the first edge
  // after release sees the board's strap level, not a driven value.
  always_ff @(posedge ref_clk) begin
    srst_d_reg <= srst;
    if (srst_d_reg && !srst) begin
      strap_reg <= strap_in; // R13
    end
  end

  assign strap_q = strap_reg;

endmodule

// File: design/phymux_top.sv
// Pin-function multiplexer and reset pin states of the PHY MAC interface.
// Overview of operation
// R1: MII collision LED only when full-duplex, configured.
// R2: RMII/RGMII collision pin LED via register.
// R3: Collision pin selectable as general_io_two.
// R4: MII/RGMII receive bit 3 stays data; the code lets a general_io_three request take it in any mode.
// R5: RMII receive bit 3 LED via register.
// R6: Receive bit 3 selectable as general_io_three.
// R7: In reset transmit clock driven low.
// R8: RGMII after reset: transmit clock is input.
// R9: Reset pulls on management, interrupt, transmit, receive clock.
// R10: Reset strap pulls up or down per pin.
// R11: Board overrides weak straps with external resistor.
// R12: Chip reset held low long enough.
// R13: Default function until selected; straps sampled at release.
`timescale 1ns/1ps
module phymux_top
  import phymux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic col_core,
  input wire logic rxd3_core,
  input wire logic led_core,
  input wire logic txclk_core,
  input wire logic col_pin_in,
  input wire logic rxd3_pin_in,
  input wire logic [PHYMUX_STRAP_W-1:0] strap_pin_in,
  output phymux_pkg::phymux_pad_t col_pad,
  output phymux_pkg::phymux_pad_t rxd3_pad,
  output phymux_pkg::phymux_pad_t txclk_pad,
  output phymux_pkg::phymux_pad_t mdio_pad,
  output phymux_pkg::phymux_pad_t mdc_pad,
  output phymux_pkg::phymux_pad_t int_n_pad,
  output phymux_pkg::phymux_pad_t txin_pad,
  output phymux_pkg::phymux_pad_t rxclk_pad,
  output logic [PHYMUX_STRAP_W-1:0] strap_pu,
  output logic [PHYMUX_STRAP_W-1:0] strap_pd
);

  import phymux_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Bus front end.
  ////////////////////////////////////////////////////////////////////////

  phymux_ahb_req_t ahb_req; // Bundled address phase.
  logic wr_stb; // Data-phase write.
  logic rd_stb; // Data-phase read.
  logic [7:0] reg_addr; // Latched address.
  logic slv_ready;
  logic slv_resp;

  assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                     hsize: hsize, hready: hready};

  phymux_ahb_slave phymux_ahb_slave_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .req(ahb_req),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .reg_addr(reg_addr),
    .hreadyout(slv_ready),
    .hresp(slv_resp)
  );

  // Straps are latched on release of reset.
  logic [PHYMUX_STRAP_W-1:0] strap_q;

  phymux_strap_latch phymux_strap_latch_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .strap_in(strap_pin_in),
    .strap_q(strap_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Software registers.
  ////////////////////////////////////////////////////////////////////////

  logic [1:0] mode_reg; // Interface mode.
  logic fdx_reg; // Full-duplex indication, written through the mode register.
  logic [1:0] colsel_reg; // Collision pin function request.
  logic [1:0] rxd3sel_reg; // Receive bit 3 function request.
  logic gio2_out_reg; // general_io_two output value.
  logic gio2_oe_reg; // general_io_two output enable.
  logic gio3_out_reg; // general_io_three output value.
  logic gio3_oe_reg; // general_io_three output enable.

  // Decoded write selects.
  wire logic wr_mode;
  wire logic wr_colsel;
  wire logic wr_rxd3sel;
  wire logic wr_gpio;
  assign wr_mode = wr_stb && reg_addr == PHYMUX_OFS_MODE;
  assign wr_colsel = wr_stb && reg_addr == PHYMUX_OFS_COLSEL;
  assign wr_rxd3sel = wr_stb && reg_addr == PHYMUX_OFS_RXD3SEL;
  assign wr_gpio = wr_stb && reg_addr == PHYMUX_OFS_GPIO;

  // Every pin starts in its interface role; only a write moves it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_reg <= PHYMUX_MODE_RST;
      fdx_reg <= 1'b0;
      colsel_reg <= PHYMUX_SEL_RST; // R13
      rxd3sel_reg <= PHYMUX_SEL_RST; // R13
      gio2_out_reg <= 1'b0;
      gio2_oe_reg <= 1'b0;
      gio3_out_reg <= 1'b0;
      gio3_oe_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= hwdata[PHYMUX_MODE_LSB +: 2];
        fdx_reg <= hwdata[PHYMUX_FDX_BIT];
      end
      if (wr_colsel) begin
        colsel_reg <= hwdata[PHYMUX_SEL_LSB +: 2];
      end
      if (wr_rxd3sel) begin
        rxd3sel_reg <= hwdata[PHYMUX_SEL_LSB +: 2];
      end
      if (wr_gpio) begin
        gio2_out_reg <= hwdata[PHYMUX_GPIO_OUT_BIT];
        gio2_oe_reg <= hwdata[PHYMUX_GPIO_OE_BIT];
        gio3_out_reg <= hwdata[PHYMUX_GPIO_OUT_BIT + 8];
        gio3_oe_reg <= hwdata[PHYMUX_GPIO_OE_BIT + 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective function of each multiplexed pin.
  ////////////////////////////////////////////////////////////////////////

  // Resolve a request against what the current mode permits.
  function automatic phymux_fn_t resolve(input logic [1:0] req, input logic led_ok);
    phymux_fn_t f;
    f = PHYMUX_FN_IFACE;
    if (req == PHYMUX_FN_GPIO) begin
      f = PHYMUX_FN_GPIO;
    end else if (req == PHYMUX_FN_LED && led_ok) begin
      f = PHYMUX_FN_LED;
    end
    return f;
  endfunction

  wire logic is_mii;
  wire logic is_rmii;
  wire logic is_rgmii;
  assign is_mii = mode_reg == PHYMUX_IF_MII;
  assign is_rmii = mode_reg == PHYMUX_IF_RMII;
  assign is_rgmii = mode_reg == PHYMUX_IF_RGMII;

  // Collision LED: MII only in full duplex, since half duplex needs the
  // collision signal; the other modes always may.
  wire logic col_led_ok;
  assign col_led_ok = (is_mii && fdx_reg) || is_rmii || is_rgmii; // R1 R2

  // Receive bit 3 is free for an LED only in RMII.
  wire logic rxd3_led_ok;
  assign rxd3_led_ok = is_rmii; // R4 R5

  wire phymux_fn_t col_fn;
  wire phymux_fn_t rxd3_fn;
  assign col_fn = resolve(colsel_reg, col_led_ok); // R1 R2 R3
  // The general-purpose role is honoured in any mode; software that
  // takes bit 3 away in MII or RGMII breaks its own data path.
  assign rxd3_fn = resolve(rxd3sel_reg, rxd3_led_ok); // R4 R6

  ////////////////////////////////////////////////////////////////////////
  // Pad next-state decode.
  ////////////////////////////////////////////////////////////////////////

  phymux_pad_t col_next;
  phymux_pad_t rxd3_next;
  phymux_pad_t txclk_next;

  always_comb begin
    col_next = '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
    case (col_fn)
      PHYMUX_FN_IFACE: col_next = '{o: col_core, oe: 1'b1, pu: 1'b0, pd: 1'b0};
      PHYMUX_FN_LED: col_next = '{o: led_core, oe: 1'b1, pu: 1'b0, pd: 1'b0}; // R1 R2
      PHYMUX_FN_GPIO: col_next = '{o: gio2_out_reg, oe: gio2_oe_reg, pu: 1'b0, pd: 1'b0}; // R3
      default: col_next = '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
    endcase
    rxd3_next = '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
    case (rxd3_fn)
      PHYMUX_FN_IFACE: rxd3_next = '{o: rxd3_core, oe: 1'b1, pu: 1'b0, pd: 1'b0}; // R4
      PHYMUX_FN_LED: rxd3_next = '{o: led_core, oe: 1'b1, pu: 1'b0, pd: 1'b0}; // R5
      PHYMUX_FN_GPIO: rxd3_next = '{o: gio3_out_reg, oe: gio3_oe_reg, pu: 1'b0, pd: 1'b0}; // R6
      default: rxd3_next = '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
    endcase
    // In RGMII the MAC sources the transmit clock once out of reset.
    if (is_rgmii) begin
      txclk_next = '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0}; // R8
    end else begin
      txclk_next = '{o: txclk_core, oe: 1'b1, pu: 1'b0, pd: 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered pads; reset forces the documented reset states.
  ////////////////////////////////////////////////////////////////////////

  // Outputs are registered, so a pad follows reset one edge later.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txclk_pad <= '{o: 1'b0, oe: 1'b1, pu: 1'b0, pd: 1'b0}; // R7
      mdio_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0}; // R9
      mdc_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1}; // R9
      int_n_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1, pd: 1'b0}; // R9
      txin_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1}; // R9
      rxclk_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1}; // R9
      col_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1, pd: 1'b0}; // R10
      rxd3_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1}; // R10
      strap_pu <= PHYMUX_STRAP_PULLUP; // R10
      strap_pd <= ~PHYMUX_STRAP_PULLUP; // R10
    end else begin
      txclk_pad <= txclk_next; // R8
      mdio_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
      mdc_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
      int_n_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
      txin_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
      rxclk_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};
      col_pad <= col_next;
      rxd3_pad <= rxd3_next;
      strap_pu <= '0;
      strap_pd <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data.
  ////////////////////////////////////////////////////////////////////////

  logic [31:0] rdata_next;

  // A read is recognised in its address phase, so that its word can stand
  // in the very next cycle; the slave inserts no wait state to buy time.
  wire logic rd_addr_ph;
  assign rd_addr_ph = hsel && hready && !hwrite && hsize == PHYMUX_HSIZE_WORD &&
                      haddr[1:0] == PHYMUX_ADDR_LSB_ZERO &&
                      (htrans == PHYMUX_HTRANS_NONSEQ || htrans == PHYMUX_HTRANS_SEQ);

  // Status shows the resolved functions and the pin levels.
  // The word is chosen by the live address, not the latched one.
  always_comb begin
    rdata_next = PHYMUX_ZERO_WORD;
    case (haddr)
      PHYMUX_OFS_MODE: rdata_next = {29'h0000_0000, fdx_reg, mode_reg};
      PHYMUX_OFS_COLSEL: rdata_next = {30'h0000_0000, colsel_reg};
      PHYMUX_OFS_RXD3SEL: rdata_next = {30'h0000_0000, rxd3sel_reg};
      PHYMUX_OFS_GPIO: rdata_next = {22'h00_0000, gio3_oe_reg, gio3_out_reg, 6'h00, gio2_oe_reg, gio2_out_reg};
      PHYMUX_OFS_STATUS: rdata_next = {22'h00_0000, rxd3_pin_in, col_pin_in, 2'h0, rxd3_fn, 2'h0, col_fn};
      PHYMUX_OFS_STRAP: rdata_next = {22'h00_0000, strap_q};
      default: rdata_next = PHYMUX_ZERO_WORD;
    endcase
  end

  // Read data is captured at the end of the address phase and stands for
  // the data phase only; the strobe of that data phase clears it again.
  // Limitation: a read issued directly behind a write to the same word
  // returns the value from before that write, since both share one edge.
  logic [31:0] hrdata_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hrdata_reg <= PHYMUX_ZERO_WORD;
    end else if (rd_addr_ph) begin
      // A new read wins over the clear of the one before it.
      hrdata_reg <= rdata_next;
    end else if (rd_stb) begin
      // Data phase over: return the bus to zero.
      hrdata_reg <= PHYMUX_ZERO_WORD;
    end
  end

  // The read bus comes straight from its flip-flop.
  assign hrdata = hrdata_reg;
  assign hreadyout = slv_ready;
  assign hresp = slv_resp;

endmodule

// File: testbench/phymux_mac_model.sv
// Behavioural MAC and board model facing the multiplexed pins.
`timescale 1ns/1ps
module phymux_mac_model
(
  input wire logic ref_clk,
  input wire phymux_pkg::phymux_pad_t col_pad,
  input wire phymux_pkg::phymux_pad_t rxd3_pad,
  input wire phymux_pkg::phymux_pad_t txclk_pad,
  input wire logic [9:0] strap_val,
  output logic col_pin_in,
  output logic rxd3_pin_in,
  output logic [9:0] strap_pin_in,
  output logic mac_txclk
);
  import phymux_pkg::*;
  // Released pins fall to the board pull: up on collision, down on bit 3.
  assign col_pin_in = col_pad.oe ? col_pad.o : 1'b1;
  assign rxd3_pin_in = rxd3_pad.oe ? rxd3_pad.o : 1'b0;
  // Board resistors override the weak internal strap pulls.
  assign strap_pin_in = strap_val;
  // The MAC runs the transmit clock only once the pin is released to it.
  initial mac_txclk = 1'b0;
  always @(posedge ref_clk) mac_txclk <= txclk_pad.oe ? 1'b0 : ~mac_txclk;
endmodule

// File: testbench/phymux_props.sv
// Checker of pad functions and reset pad states at the ports of the pin block.
`timescale 1ns/1ps
module phymux_props
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic col_core,
  input wire logic rxd3_core,
  input wire logic led_core,
  input wire phymux_pkg::phymux_pad_t col_pad,
  input wire phymux_pkg::phymux_pad_t rxd3_pad,
  input wire phymux_pkg::phymux_pad_t txclk_pad,
  input wire phymux_pkg::phymux_pad_t mdio_pad,
  input wire phymux_pkg::phymux_pad_t mdc_pad,
  input wire phymux_pkg::phymux_pad_t int_n_pad,
  input wire phymux_pkg::phymux_pad_t txin_pad,
  input wire phymux_pkg::phymux_pad_t rxclk_pad,
  input wire logic [phymux_pkg::PHYMUX_STRAP_W-1:0] strap_pu,
  input wire logic [phymux_pkg::PHYMUX_STRAP_W-1:0] strap_pd
);
  import phymux_pkg::*;
  // Shadow copies of the selection registers, rebuilt from bus writes.
  logic aw_reg;
  logic [7:0] aa_reg;
  logic [2:0] mode_sh;
  logic [1:0] col_sh;
  logic [1:0] rx_sh;
  logic [31:0] gp_sh;
  wire col_led_ok = (mode_sh[1:0] == PHYMUX_IF_MII && mode_sh[2]) || mode_sh[1:0] == PHYMUX_IF_RMII ||
                    mode_sh[1:0] == PHYMUX_IF_RGMII;
  // Capture each word write address phase, then its data one cycle later.
  always_ff @(posedge ref_clk) begin
    aw_reg <= !srst && hsel && hready && htrans[1] && hwrite && (hsize == PHYMUX_HSIZE_WORD);
    aa_reg <= haddr;
  end
  // Shadows reset with the design so decode checks hold after any reset.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_sh <= 3'h0;
      col_sh <= 2'h0;
      rx_sh <= 2'h0;
      gp_sh <= 32'h0000_0000;
    end else if (aw_reg) begin
      if (aa_reg == PHYMUX_OFS_MODE) mode_sh <= hwdata[2:0];
      if (aa_reg == PHYMUX_OFS_COLSEL) col_sh <= hwdata[1:0];
      if (aa_reg == PHYMUX_OFS_RXD3SEL) rx_sh <= hwdata[1:0];
      if (aa_reg == PHYMUX_OFS_GPIO) gp_sh <= hwdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Selection unchanged over the last cycle, so the registered pads settled.
  sequence s_steady;
    !$past(srst) && $stable(mode_sh) && $stable(col_sh) && $stable(rx_sh) && $stable(gp_sh);
  endsequence
  AST_TXCLK_RESET: assert property (disable iff (1'b0) srst |=> txclk_pad.oe && !txclk_pad.o)
    else $error("transmit clock pad not driven low in reset");
  AST_MGMT_RESET: assert property (disable iff (1'b0) srst |=> mdio_pad == 4'h0 && mdc_pad == 4'h1 && int_n_pad == 4'h2)
    else $error("management pads wrong in reset");
  AST_TXRX_RESET: assert property (disable iff (1'b0) srst |=> txin_pad == 4'h1 && rxclk_pad == 4'h1)
    else $error("transmit inputs or receive clock pad wrong in reset");
  AST_STRAP_RESET: assert property (disable iff (1'b0) srst |=> strap_pu == PHYMUX_STRAP_PULLUP
    && strap_pd == ~PHYMUX_STRAP_PULLUP && col_pad == 4'h2 && rxd3_pad == 4'h1)
    else $error("strap pulls wrong in reset");
  AST_RXD3_DATA: assert property (s_steady ##0 (mode_sh[1:0] != PHYMUX_IF_RMII && rx_sh != PHYMUX_FN_GPIO)
    |-> rxd3_pad.oe && rxd3_pad.o == $past(rxd3_core))
    else $error("receive bit 3 left its data role");
  AST_RXD3_LED: assert property (s_steady ##0 (mode_sh[1:0] == PHYMUX_IF_RMII && rx_sh == PHYMUX_FN_LED)
    |-> rxd3_pad.o == $past(led_core))
    else $error("receive bit 3 not driving the indicator");
  AST_COL_FN: assert property (s_steady ##0 col_sh == PHYMUX_FN_LED
    |-> col_pad.o == (col_led_ok ? $past(led_core) : $past(col_core)))
    else $error("collision pad function wrong");
  AST_GENERAL_IO_TWO: assert property (s_steady ##0 col_sh == PHYMUX_FN_GPIO
    |-> col_pad.oe == gp_sh[1] && (!gp_sh[1] || col_pad.o == gp_sh[0]))
    else $error("collision pad not following general_io_two");
  AST_GENERAL_IO_THREE: assert property (s_steady ##0 rx_sh == PHYMUX_FN_GPIO
    |-> rxd3_pad.oe == gp_sh[9] && (!gp_sh[9] || rxd3_pad.o == gp_sh[8]))
    else $error("bit 3 pad not following general_io_three");
  AST_TXCLK_IN: assert property (s_steady ##0 mode_sh[1:0] == PHYMUX_IF_RGMII |-> !txclk_pad.oe)
    else $error("transmit clock pad still driven in the gigabit-style mode");
endmodule

bind phymux_top phymux_props phymux_props_inst (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .col_core, .rxd3_core, .led_core, .col_pad, .rxd3_pad, .txclk_pad, .mdio_pad, .mdc_pad,
  .int_n_pad, .txin_pad, .rxclk_pad, .strap_pu, .strap_pd);

// File: testbench/test_phy_pin_function_and_reset_states.sv
// Self-checking testbench of the PHY pin-function block.
`timescale 1ns/1ps
module test_phy_pin_function_and_reset_states;
  import phymux_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd_smp;
  logic [31:0] q;
  logic col_core = 1'b0;
  logic rxd3_core = 1'b0;
  logic led_core = 1'b1;
  logic txclk_core = 1'b0;
  logic [9:0] strap_val = 10'h2a5;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, col_pin_in, rxd3_pin_in, mac_txclk;
  wire logic [9:0] strap_pin_in, strap_pu, strap_pd;
  phymux_pad_t col_pad, rxd3_pad, txclk_pad, mdio_pad, mdc_pad, int_n_pad, txin_pad, rxclk_pad;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  // Read data is taken at the data-phase edge, before the slave clears it.
  always @(posedge ref_clk) rd_smp <= hrdata;
  phymux_top phymux_top_inst (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(PHYMUX_HSIZE_WORD),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .col_core, .rxd3_core, .led_core, .txclk_core,
    .col_pin_in, .rxd3_pin_in, .strap_pin_in, .col_pad, .rxd3_pad, .txclk_pad, .mdio_pad, .mdc_pad,
    .int_n_pad, .txin_pad, .rxclk_pad, .strap_pu, .strap_pd);
  phymux_mac_model phymux_mac_model_inst (.ref_clk, .col_pad, .rxd3_pad, .txclk_pad, .strap_val,
    .col_pin_in, .rxd3_pin_in, .strap_pin_in, .mac_txclk);
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single-word transfer; waits on hready in both phases.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PHYMUX_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    #1;
    q = rd_smp;
  endtask
  // Pads are registered from the selection, so allow a few edges to land.
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_reset(input logic [9:0] sv);
    @(posedge ref_clk);
    srst <= 1'b1;
    strap_val <= sv;
    // The block's reset is synchronous and needs one edge; the chip pin's
    // longer minimum low time is met upstream of this reset.
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk("txclk_rst", txclk_pad, 4'h4);
    chk("mgmt_rst", {mdio_pad, mdc_pad, int_n_pad}, 12'h012);
    chk("strap_pulls", {strap_pd, strap_pu}, 20'hf_c00f);
    xfer(1'b0, PHYMUX_OFS_STRAP, 32'h0000_0000);
    chk("strap", q, {22'h0, sv});
    xfer(1'b0, PHYMUX_OFS_COLSEL, 32'h0000_0000);
    chk("colsel", q, 32'h0000_0000);
    $display("test reset done");
  endtask
  // Every interface mode, MII with and without full duplex, then both GPIO roles.
  task automatic t_modes();
    logic [2:0] md [4] = '{3'h0, 3'h4, 3'h1, 3'h2};
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, PHYMUX_OFS_MODE, {29'h0, md[i]});
      xfer(1'b1, PHYMUX_OFS_COLSEL, 32'h0000_0001);
      xfer(1'b1, PHYMUX_OFS_RXD3SEL, 32'h0000_0001);
      xfer(1'b1, PHYMUX_OFS_GPIO, 32'h0000_0000);
      settle();
      chk("col_led", col_pad.o, (i == 0) ? col_core : led_core);
      chk("rxd3_led", rxd3_pad.o, (i == 2) ? led_core : rxd3_core);
      chk("txclk_oe", txclk_pad.oe, i != 3);
      xfer(1'b1, PHYMUX_OFS_COLSEL, 32'h0000_0002);
      xfer(1'b1, PHYMUX_OFS_RXD3SEL, 32'h0000_0002);
      xfer(1'b1, PHYMUX_OFS_GPIO, 32'h0000_0303);
      settle();
      chk("col_gpio", {col_pad.oe, col_pad.o}, 2'h3);
      chk("rxd3_gpio", {rxd3_pad.oe, rxd3_pad.o}, 2'h3);
      xfer(1'b0, PHYMUX_OFS_STATUS, 32'h0000_0000);
      chk("status", q, 32'h0000_0322);
    end
    $display("test modes done");
  endtask
  // A write to an unmapped word is dropped and it reads back as zero.
  task automatic t_unmap();
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    xfer(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    chk("hresp", hresp, 1'b0);
    xfer(1'b0, PHYMUX_OFS_MODE, 32'h0000_0000);
    chk("mode", q, 32'h0000_0002);
    $display("test unmapped done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A hung handshake is cut short well past the roughly 150 cycles needed.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    t_reset(10'h2a5);
    t_modes();
    t_unmap();
    t_reset(10'h15a);
    tally_and_finish();
  end
endmodule
